// ==== design/spcdp_pkg.sv ====
// Purpose: Shared constants and carriers of the PHY control and discover page.
// Assumes: One page per device, two ports, one PHY per port.
// Notes: Byte offsets are page byte indices as read over the sense port.
`default_nettype none
package spcdp_pkg;
   // -----------------------------------------------------------
   // Page header
   // -----------------------------------------------------------
   localparam logic parameters_savable = 1'b1;
   localparam logic subpage_format_flag = 1'b1;
   localparam logic [5:0] PAGE_CODE = 6'h19;
   localparam logic [7:0] SUBPAGE_PHY_CTL = 8'h01;
   localparam logic [15:0] PAGE_LEN_RST = 16'h0064;
   localparam logic [3:0] PROTOCOL_TAG_RST = 4'h6;
   localparam logic [7:0] CHANGE_CNT_RST = 8'h00;
   localparam logic [7:0] CHANGE_CNT_MAX = 8'hFF;
   localparam logic [7:0] CHANGE_CNT_WRAP = 8'h01;
   localparam logic [7:0] PHY_COUNT_RST = 8'h02;
   localparam int NUM_PHY = 2;
   // -----------------------------------------------------------
   // Page byte offsets
   // -----------------------------------------------------------
   localparam logic [6:0] OFS_PAGE_CODE = 7'h00;
   localparam logic [6:0] OFS_SUBPAGE = 7'h01;
   localparam logic [6:0] OFS_LEN_MSB = 7'h02;
   localparam logic [6:0] OFS_LEN_LSB = 7'h03;
   localparam logic [6:0] OFS_PROTOCOL = 7'h05;
   localparam logic [6:0] OFS_CHANGE_CNT = 7'h06;
   localparam logic [6:0] OFS_PHY_COUNT = 7'h07;
   localparam logic [6:0] OFS_DESC0 = 7'h08;
   localparam logic [6:0] OFS_DESC1 = 7'h38;
   localparam logic [6:0] DESC_BYTES = 7'h30;
   // -----------------------------------------------------------
   // Descriptor byte offsets
   // -----------------------------------------------------------
   localparam logic [5:0] D_PHY_NUMBER = 6'h01;
   localparam logic [5:0] D_TYPE_REASON = 6'h04;
   localparam logic [5:0] D_REASON_RATE = 6'h05;
   localparam logic [5:0] D_INIT_FLAGS = 6'h06;
   localparam logic [5:0] D_TGT_FLAGS = 6'h07;
   localparam logic [5:0] D_OWN_ADDR = 6'h08;
   localparam logic [5:0] D_ATT_ADDR = 6'h10;
   localparam logic [5:0] D_ATT_PHY = 6'h18;
   localparam logic [5:0] D_ATT_CAPS = 6'h19;
   localparam logic [5:0] D_MIN_RATES = 6'h20;
   localparam logic [5:0] D_MAX_RATES = 6'h21;
   localparam logic [5:0] D_VENDOR_MSB = 6'h2A;
   localparam logic [5:0] D_VENDOR_LSB = 6'h2B;
   localparam logic [15:0] VENDOR_FIELD_RST = 16'h0000;
   localparam logic [7:0] PHY_NUMBER_0 = 8'h00;
   localparam logic [7:0] PHY_NUMBER_1 = 8'h01;
   localparam logic [3:0] PROG_MIN_RST = 4'h8;
   localparam logic [3:0] PROG_MAX_RST = 4'hA;
   // -----------------------------------------------------------
   // Error answer
   // -----------------------------------------------------------
   localparam logic [3:0] SENSE_ILLEGAL_REQ = 4'h5;
   localparam logic [7:0] ASC_BAD_PARAM_FIELD = 8'h26;
   // -----------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------
   typedef struct packed {
      logic [2:0] dev_type;
      logic [3:0] reason;
      logic [2:0] init_flags;
      logic [2:0] tgt_flags;
      logic [63:0] addr;
      logic [7:0] phy_number;
      logic [7:0] caps;
   } spcdp_idf_s;
   typedef struct packed {
      logic [3:0] reason;
      logic [3:0] neg_rate;
   } spcdp_link_s;
   typedef struct packed {
      logic [3:0] min_rate;
      logic [3:0] max_rate;
   } spcdp_rate_s;
endpackage
`default_nettype wire

// ==== design/spcdp_desc_fmt.sv ====
// Purpose: Forms one byte of a PHY descriptor from its stored fields.
// Assumes: Index is 0 to 47 within the descriptor.
// Notes: Pure selection; the caller registers the result.
`default_nettype none
`timescale 1ns/10ps
module spcdp_desc_fmt
   import spcdp_pkg::*;
(
   input wire logic [5:0] idx_in,
   input wire logic [7:0] phy_number_in,
   input wire spcdp_idf_s idf_in,
   input wire spcdp_link_s link_in,
   input wire logic [63:0] own_addr_in,
   input wire spcdp_rate_s hw_in,
   input wire spcdp_rate_s prog_in,
   output logic [7:0] byte_out
);
   always_comb begin
      byte_out = 8'h00;
      case (idx_in)
         D_PHY_NUMBER: byte_out = phy_number_in;
         D_TYPE_REASON: byte_out = {1'b0, idf_in.dev_type, idf_in.reason};
         D_REASON_RATE: byte_out = {link_in.reason, link_in.neg_rate};
         D_INIT_FLAGS: byte_out = {4'h0, idf_in.init_flags, 1'b0};
         D_TGT_FLAGS: byte_out = {4'h0, idf_in.tgt_flags, 1'b0};
         D_ATT_PHY: byte_out = idf_in.phy_number;
         D_ATT_CAPS: byte_out = idf_in.caps;
         D_MIN_RATES: byte_out = {prog_in.min_rate, hw_in.min_rate};
         D_MAX_RATES: byte_out = {prog_in.max_rate, hw_in.max_rate};
         D_VENDOR_MSB: byte_out = VENDOR_FIELD_RST[15:8];
         D_VENDOR_LSB: byte_out = VENDOR_FIELD_RST[7:0];
         default: begin
            // Own address at 8..15, attached address at 16..23, MSB first
            if (idx_in >= D_OWN_ADDR && idx_in < D_ATT_ADDR) begin
               byte_out = own_addr_in[8'(7 - (idx_in - D_OWN_ADDR)) * 8 +: 8];
            end else if (idx_in >= D_ATT_ADDR && idx_in < D_ATT_PHY) begin
               byte_out = idf_in.addr[8'(7 - (idx_in - D_ATT_ADDR)) * 8 +: 8];
            end else begin
               byte_out = 8'h00;
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// ==== design/spcdp_page.sv ====
// Purpose: PHY control and discover page for a dual-port target.
// Assumes: Sense and select requests are single-byte accesses, one per cycle each.
// Notes: Fields of the last identify frame are captured per PHY.
//
// Function
// - Add one to the change counter whenever any page value changes; changes of the hardware rates or own address are not counted.
// - Change counter value zero means unknown; increments never produce it.
// - At FFh the change counter wraps to 01h, not 00h.
// - Report two PHYs and carry exactly two descriptors.
// - Protocol tag in byte five always reads six.
// - Page length at bytes two and three reads fixed 0064h, MSB first.
// - Port 0 descriptor at bytes 8-55, port 1 at 56-103.
// - A mode-sense request returns the current page settings.
// - Each descriptor carries a unique PHY number.
// - Attached reason and device type come from the latest identify frame.
// - Attached address and PHY number come from the latest identify frame.
// - Byte 25 holds the capability bits of the latest identify frame.
// - Descriptor bytes 8-15 hold the port's own 64-bit address.
// - Lower nibbles of bytes 32, 33 give hardware link rate limits.
// - Upper nibbles of bytes 32, 33 give programmed link rate limits.
// - Unsupported subpage ends the command as illegal request, bad field.
`default_nettype none
`timescale 1ns/10ps
module spcdp_page
   import spcdp_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic sense_req_in,
   input wire logic [7:0] sense_subpage_in,
   input wire logic [6:0] sense_addr_in,
   output logic sense_valid_out,
   output logic [7:0] sense_data_out,
   input wire logic select_req_in,
   input wire logic [7:0] select_subpage_in,
   input wire logic [6:0] select_addr_in,
   input wire logic [7:0] select_data_in,
   output logic select_done_out,
   output logic cmd_err_out,
   output logic [3:0] err_sense_key_out,
   output logic [7:0] err_asc_out,
   input wire logic [1:0] idf_valid_in,
   input wire spcdp_idf_s [1:0] idf_frame_in,
   input wire spcdp_link_s [1:0] link_state_in,
   input wire spcdp_rate_s [1:0] hw_rates_in,
   input wire logic [1:0][63:0] own_addr_in,
   output spcdp_rate_s [1:0] prog_rates_out,
   output logic [7:0] change_counter_out
);
   // ----------------------------------------------------------------
   // Per-PHY storage and descriptor formatting
   // ----------------------------------------------------------------
   spcdp_idf_s [1:0] idf_r;
   spcdp_link_s [1:0] link_r;
   spcdp_rate_s [1:0] prog_r;
   logic [1:0][7:0] desc_byte;
   logic [1:0] phy_changed;
   logic [1:0] sel_hit_min;
   logic [1:0] sel_hit_max;
   logic [1:0] sel_in_desc;
   logic [1:0][5:0] rd_idx;
   logic [1:0][5:0] wr_idx;
   logic [1:0] rd_in_desc;
   logic sel_ok;
   logic sense_ok;

   assign sense_ok = (sense_subpage_in == SUBPAGE_PHY_CTL);
   assign sel_ok = (select_subpage_in == SUBPAGE_PHY_CTL);

   genvar g;
   generate
      for (g = 0; g < NUM_PHY; g++) begin : g_phy
         localparam logic [6:0] BASE = (g == 0) ? OFS_DESC0 : OFS_DESC1;
         localparam logic [7:0] PNUM = (g == 0) ? PHY_NUMBER_0 : PHY_NUMBER_1;
         logic [6:0] rd_off;
         logic [6:0] wr_off;
         logic idf_diff;
         logic link_diff;
         logic prog_diff;

         assign rd_off = sense_addr_in - BASE;
         assign wr_off = select_addr_in - BASE;
         assign rd_in_desc[g] = (sense_addr_in >= BASE) && (rd_off < DESC_BYTES);
         assign sel_in_desc[g] = (select_addr_in >= BASE) && (wr_off < DESC_BYTES);
         assign rd_idx[g] = rd_off[5:0];
         assign wr_idx[g] = wr_off[5:0];
         assign sel_hit_min[g] = select_req_in && sel_ok && sel_in_desc[g]
                                 && (wr_idx[g] == D_MIN_RATES);
         assign sel_hit_max[g] = select_req_in && sel_ok && sel_in_desc[g]
                                 && (wr_idx[g] == D_MAX_RATES);

         // --------------------------------------------------------
         // Identify frame capture
         // --------------------------------------------------------
         always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               idf_r[g] <= '0;
            end else if (idf_valid_in[g]) begin
               idf_r[g] <= idf_frame_in[g];
            end
         end

         // --------------------------------------------------------
         // Link status follower
         // --------------------------------------------------------
         always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               link_r[g] <= '0;
            end else begin
               link_r[g] <= link_state_in[g];
            end
         end

         // --------------------------------------------------------
         // Programmed link rates, written through mode select
         // --------------------------------------------------------
         always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               prog_r[g].min_rate <= PROG_MIN_RST;
               prog_r[g].max_rate <= PROG_MAX_RST;
            end else begin
               // Only the upper nibble is stored; the hardware nibble ignores writes
               if (sel_hit_min[g]) begin
                  prog_r[g].min_rate <= select_data_in[7:4];
               end
               if (sel_hit_max[g]) begin
                  prog_r[g].max_rate <= select_data_in[7:4];
               end
            end
         end

         // Any difference in a stored field counts as a page change
         assign idf_diff = idf_valid_in[g] && (idf_frame_in[g] != idf_r[g]);
         assign link_diff = (link_state_in[g] != link_r[g]);
         assign prog_diff = (sel_hit_min[g] && (select_data_in[7:4] != prog_r[g].min_rate))
                            || (sel_hit_max[g] && (select_data_in[7:4] != prog_r[g].max_rate));
         assign phy_changed[g] = idf_diff || link_diff || prog_diff;

         spcdp_desc_fmt u_fmt (
            .idx_in(rd_idx[g]),
            .phy_number_in(PNUM),
            .idf_in(idf_r[g]),
            .link_in(link_r[g]),
            .own_addr_in(own_addr_in[g]),
            .hw_in(hw_rates_in[g]),
            .prog_in(prog_r[g]),
            .byte_out(desc_byte[g])
         );
      end
   endgenerate

   assign prog_rates_out = prog_r;

   // ----------------------------------------------------------------
   // Change counter
   // ----------------------------------------------------------------
   logic [7:0] change_counter_r;
   logic [7:0] change_counter_nxt;

   always_comb begin
      change_counter_nxt = change_counter_r;
      if (|phy_changed) begin
         if (change_counter_r == CHANGE_CNT_MAX) begin
            change_counter_nxt = CHANGE_CNT_WRAP;
         end else begin
            change_counter_nxt = change_counter_r + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         change_counter_r <= CHANGE_CNT_RST;
      end else begin
         change_counter_r <= change_counter_nxt;
      end
   end

   assign change_counter_out = change_counter_r;

   // ----------------------------------------------------------------
   // Page byte selection for mode sense
   // ----------------------------------------------------------------
   logic [7:0] page_byte;

   always_comb begin
      page_byte = 8'h00;
      if (rd_in_desc[0]) begin
         page_byte = desc_byte[0];
      end else if (rd_in_desc[1]) begin
         page_byte = desc_byte[1];
      end else begin
         case (sense_addr_in)
            OFS_PAGE_CODE: page_byte = {parameters_savable, subpage_format_flag, PAGE_CODE};
            OFS_SUBPAGE: page_byte = SUBPAGE_PHY_CTL;
            OFS_LEN_MSB: page_byte = PAGE_LEN_RST[15:8];
            OFS_LEN_LSB: page_byte = PAGE_LEN_RST[7:0];
            OFS_PROTOCOL: page_byte = {4'h0, PROTOCOL_TAG_RST};
            OFS_CHANGE_CNT: page_byte = change_counter_r;
            OFS_PHY_COUNT: page_byte = PHY_COUNT_RST;
            default: page_byte = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sense answer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sense_valid_out <= 1'b0;
         sense_data_out <= 8'h00;
      end else begin
         sense_valid_out <= sense_req_in && sense_ok;
         if (sense_req_in && sense_ok) begin
            sense_data_out <= page_byte;
         end
      end
   end

   // ----------------------------------------------------------------
   // Select answer and command error
   // ----------------------------------------------------------------
   logic bad_req;

   assign bad_req = (sense_req_in && !sense_ok) || (select_req_in && !sel_ok);

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         select_done_out <= 1'b0;
         cmd_err_out <= 1'b0;
         err_sense_key_out <= 4'h0;
         err_asc_out <= 8'h00;
      end else begin
         select_done_out <= select_req_in;
         cmd_err_out <= bad_req;
         if (bad_req) begin
            err_sense_key_out <= SENSE_ILLEGAL_REQ;
            err_asc_out <= ASC_BAD_PARAM_FIELD;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/spcdp_page_assertions.sv ====
// Purpose: Port-level checks of the PHY control and discover page.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every spcdp_page instance.
`default_nettype none
`timescale 1ns/10ps
module spcdp_page_assertions
   import spcdp_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic sense_req_in,
   input wire logic [7:0] sense_subpage_in,
   input wire logic [6:0] sense_addr_in,
   input wire logic sense_valid_out,
   input wire logic [7:0] sense_data_out,
   input wire logic select_req_in,
   input wire logic [7:0] select_subpage_in,
   input wire logic [6:0] select_addr_in,
   input wire logic [7:0] select_data_in,
   input wire logic select_done_out,
   input wire logic cmd_err_out,
   input wire logic [3:0] err_sense_key_out,
   input wire logic [7:0] err_asc_out,
   input wire spcdp_link_s [1:0] link_state_in,
   input wire spcdp_rate_s [1:0] prog_rates_out,
   input wire logic [7:0] change_counter_out
);
   default clocking dc @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   AST_SENSE_OK: assert property (sense_req_in && sense_subpage_in == SUBPAGE_PHY_CTL
      |=> sense_valid_out && !cmd_err_out) else $error("read not answered");
   AST_SENSE_BAD: assert property (sense_req_in && sense_subpage_in != SUBPAGE_PHY_CTL
      |=> cmd_err_out && !sense_valid_out) else $error("bad subpage read accepted");
   AST_ERR_CODE: assert property (cmd_err_out |-> err_sense_key_out == SENSE_ILLEGAL_REQ
      && err_asc_out == ASC_BAD_PARAM_FIELD) else $error("wrong error codes");
   AST_SEL_DONE: assert property (select_req_in |=> select_done_out)
      else $error("write not acknowledged");
   AST_PROG_MIN0: assert property (select_req_in && select_subpage_in == SUBPAGE_PHY_CTL
      && select_addr_in == 7'h28 |=> {prog_rates_out[0].min_rate, 4'h0}
      == ($past(select_data_in) & 8'hF0)) else $error("minimum rate not stored");
   AST_PHY_COUNT: assert property (sense_req_in && sense_subpage_in == SUBPAGE_PHY_CTL
      && sense_addr_in == OFS_PHY_COUNT |=> sense_data_out == PHY_COUNT_RST)
      else $error("wrong PHY count");
   AST_CNT_STEP: assert property ($changed(change_counter_out)
      && $past(change_counter_out) != CHANGE_CNT_MAX
      |-> change_counter_out == $past(change_counter_out) + 8'h01) else $error("counter skipped");
   AST_CNT_NONZERO: assert property ($changed(change_counter_out)
      |-> change_counter_out != CHANGE_CNT_RST) else $error("counter stepped to zero");
   AST_CNT_WRAP: assert property (change_counter_out == CHANGE_CNT_MAX ##1
      $changed(change_counter_out) |-> change_counter_out == CHANGE_CNT_WRAP)
      else $error("counter wrap wrong");
   AST_LINK_BUMP: assert property ($changed(link_state_in)
      |=> $changed(change_counter_out)) else $error("link change not counted");
endmodule
bind spcdp_page spcdp_page_assertions u_spcdp_page_assertions (.sys_clk_in, .arst_n_in,
   .sense_req_in, .sense_subpage_in, .sense_addr_in, .sense_valid_out, .sense_data_out,
   .select_req_in, .select_subpage_in, .select_addr_in, .select_data_in, .select_done_out,
   .cmd_err_out, .err_sense_key_out, .err_asc_out, .link_state_in, .prog_rates_out,
   .change_counter_out);
`default_nettype wire

// ==== verification/spcdp_phy_model.sv ====
// Purpose: Behavioural attached PHY pair and port straps.
// Assumes: Driven by the bench through its tasks.
// Notes: Identify fields show the inverse once the valid cycle is over.
`default_nettype none
`timescale 1ns/10ps
module spcdp_phy_model
   import spcdp_pkg::*;
(
   input wire logic sys_clk_in,
   output logic [1:0] idf_valid_out,
   output spcdp_idf_s [1:0] idf_frame_out,
   output spcdp_link_s [1:0] link_state_out,
   output spcdp_rate_s [1:0] hw_rates_out,
   output logic [1:0][63:0] own_addr_out
);
   // Arbitrary port addresses
   assign own_addr_out = {64'h5000_C0DE_0000_0B01, 64'h5000_C0DE_0000_0B00};
   assign hw_rates_out = {8'h8B, 8'h9A};
   initial begin
      idf_valid_out = 2'h0;
      idf_frame_out = '1;
      link_state_out = '0;
   end
   task automatic send_identify(input int p, input spcdp_idf_s f);
      @(posedge sys_clk_in);
      idf_valid_out[p] <= 1'b1;
      idf_frame_out[p] <= f;
      @(posedge sys_clk_in);
      idf_valid_out[p] <= 1'b0;
      idf_frame_out[p] <= ~f;
   endtask
   task automatic set_link(input int p, input spcdp_link_s v);
      @(posedge sys_clk_in);
      link_state_out[p] <= v;
   endtask
endmodule
`default_nettype wire

// ==== verification/test_sas_phy_control_discover_page.sv ====
// Purpose: Self-checking bench of the PHY control and discover page.
// Assumes: Attached PHYs come from spcdp_phy_model.
// Notes: The change counter is tracked by the bench itself.
`default_nettype none
`timescale 1ns/10ps
module test_sas_phy_control_discover_page;
   import spcdp_pkg::*;
   logic sys_clk, arst_n, s_req, w_req, s_valid, w_done, err;
   logic [7:0] s_sub, w_sub, w_data, s_data, asc, cnt, exp_cnt;
   logic [6:0] s_addr, w_addr;
   logic [3:0] key;
   logic [1:0] idf_v;
   spcdp_idf_s [1:0] idf_f;
   spcdp_link_s [1:0] link;
   spcdp_rate_s [1:0] hw, prog;
   logic [1:0][63:0] own;
   int n_errors, tests_run, cyc;
   spcdp_phy_model u_spcdp_phy_model (.sys_clk_in(sys_clk), .idf_valid_out(idf_v),
      .idf_frame_out(idf_f), .link_state_out(link), .hw_rates_out(hw), .own_addr_out(own));
   spcdp_page u_spcdp_page (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .sense_req_in(s_req),
      .sense_subpage_in(s_sub), .sense_addr_in(s_addr), .sense_valid_out(s_valid),
      .sense_data_out(s_data), .select_req_in(w_req), .select_subpage_in(w_sub),
      .select_addr_in(w_addr), .select_data_in(w_data), .select_done_out(w_done),
      .cmd_err_out(err), .err_sense_key_out(key), .err_asc_out(asc), .idf_valid_in(idf_v),
      .idf_frame_in(idf_f), .link_state_in(link), .hw_rates_in(hw), .own_addr_in(own),
      .prog_rates_out(prog), .change_counter_out(cnt));
   function automatic logic [7:0] nxt(input logic [7:0] c);
      return (c == CHANGE_CNT_MAX) ? CHANGE_CNT_WRAP : c + 8'h01;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] sub, input logic [6:0] a, input logic [7:0] exp);
      logic ok;
      ok = (sub == SUBPAGE_PHY_CTL);
      @(posedge sys_clk);
      s_req <= 1'b1;
      s_sub <= sub;
      s_addr <= a;
      @(posedge sys_clk);
      s_req <= 1'b0;
      #1;
      chk({6'h00, err, s_valid}, {6'h00, !ok, ok}, "read answer");
      if (ok) chk(s_data, exp, "read data");
      else begin
         chk({4'h0, key}, {4'h0, SENSE_ILLEGAL_REQ}, "sense key");
         chk(asc, ASC_BAD_PARAM_FIELD, "sense code");
      end
   endtask
   task automatic wr(input logic [7:0] sub, input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      w_req <= 1'b1;
      w_sub <= sub;
      w_addr <= a;
      w_data <= d;
      @(posedge sys_clk);
      w_req <= 1'b0;
      #1;
      chk({6'h00, err, w_done}, {6'h00, sub != SUBPAGE_PHY_CTL, 1'b1}, "write answer");
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
      chk(cnt, exp_cnt, "counter");
   endtask
   task automatic t_header();
      logic [7:0] hdr [8];
      hdr = '{8'hD9, 8'h01, 8'h00, 8'h64, 8'h00, 8'h06, 8'h00, 8'h02};
      for (int i = 0; i < 8; i++) rd(SUBPAGE_PHY_CTL, 7'(i), hdr[i]);
      rd(SUBPAGE_PHY_CTL, 7'd104, 8'h00);
      rd(SUBPAGE_PHY_CTL, 7'd34, 8'h00);
      rd(SUBPAGE_PHY_CTL, 7'd9, PHY_NUMBER_0);
      rd(SUBPAGE_PHY_CTL, 7'd57, PHY_NUMBER_1);
      $display("header test done");
   endtask
   task automatic t_identify();
      spcdp_idf_s f;
      logic [6:0] b;
      for (int p = 0; p < 2; p++) begin
         b = p ? OFS_DESC1 : OFS_DESC0;
         f = {3'(p + 1), 4'h3, 3'h5, 3'h2, 64'hA1B2_C3D4_E5F6_0718 ^ 64'(p), 8'(p + 4), 8'hA5};
         u_spcdp_phy_model.send_identify(p, f);
         exp_cnt = nxt(exp_cnt);
         settle();
         rd(SUBPAGE_PHY_CTL, b + 7'd4, {1'b0, f.dev_type, f.reason});
         rd(SUBPAGE_PHY_CTL, b + 7'd6, {4'h0, f.init_flags, 1'b0});
         rd(SUBPAGE_PHY_CTL, b + 7'd7, {4'h0, f.tgt_flags, 1'b0});
         for (int i = 0; i < 8; i++) rd(SUBPAGE_PHY_CTL, b + 7'(16 + i), f.addr[63 - 8 * i -: 8]);
         for (int i = 0; i < 8; i++) rd(SUBPAGE_PHY_CTL, b + 7'(8 + i), own[p][63 - 8 * i -: 8]);
         rd(SUBPAGE_PHY_CTL, b + 7'd24, f.phy_number);
         rd(SUBPAGE_PHY_CTL, b + 7'd25, f.caps);
         u_spcdp_phy_model.send_identify(p, f);
         settle();
      end
      $display("identify test done");
   endtask
   task automatic t_rates();
      logic [6:0] b;
      for (int p = 0; p < 2; p++) begin
         b = p ? OFS_DESC1 : OFS_DESC0;
         rd(SUBPAGE_PHY_CTL, b + 7'd32, {PROG_MIN_RST, hw[p].min_rate});
         rd(SUBPAGE_PHY_CTL, b + 7'd33, {PROG_MAX_RST, hw[p].max_rate});
         wr(SUBPAGE_PHY_CTL, b + 7'd32, 8'h9F);
         wr(SUBPAGE_PHY_CTL, b + 7'd33, 8'hB0);
         exp_cnt = nxt(nxt(exp_cnt));
         settle();
         rd(SUBPAGE_PHY_CTL, b + 7'd32, {4'h9, hw[p].min_rate});
         rd(SUBPAGE_PHY_CTL, b + 7'd33, {4'hB, hw[p].max_rate});
         wr(SUBPAGE_PHY_CTL, b + 7'd33, 8'hB5);
         settle();
      end
      wr(SUBPAGE_PHY_CTL, OFS_LEN_LSB, 8'hFF);
      rd(SUBPAGE_PHY_CTL, OFS_LEN_LSB, 8'h64);
      $display("rates test done");
   endtask
   task automatic t_bad();
      logic [7:0] subs [3];
      subs = '{8'h00, 8'h02, 8'hFF};
      foreach (subs[i]) begin
         rd(subs[i], OFS_PHY_COUNT, 8'h00);
         wr(subs[i], 7'h28, 8'h7F);
      end
      rd(SUBPAGE_PHY_CTL, 7'h28, {4'h9, hw[0].min_rate});
      settle();
      $display("bad subpage test done");
   endtask
   task automatic t_wrap();
      spcdp_link_s v;
      v = 8'h5A;
      while (exp_cnt != CHANGE_CNT_MAX) begin
         v = ~v;
         u_spcdp_phy_model.set_link(0, v);
         exp_cnt = nxt(exp_cnt);
         @(posedge sys_clk);
      end
      settle();
      v = ~v;
      u_spcdp_phy_model.set_link(0, v);
      exp_cnt = nxt(exp_cnt);
      settle();
      rd(SUBPAGE_PHY_CTL, OFS_DESC0 + 7'd5, v);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(cnt, CHANGE_CNT_RST, "counter reset");
      chk(prog[0], {PROG_MIN_RST, PROG_MAX_RST}, "rates reset");
      @(posedge sys_clk);
      arst_n <= 1'b1;
      exp_cnt = CHANGE_CNT_WRAP;
      settle();
      $display("wrap and reset test done");
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         $display("[FAIL] %0t run too long", $time);
         close_out();
      end
   end
   initial begin
      {arst_n, s_req, w_req, s_sub, w_sub, w_data, s_addr, w_addr} = '0;
      exp_cnt = CHANGE_CNT_RST;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_header();
      t_identify();
      t_rates();
      t_bad();
      t_wrap();
      close_out();
   end
endmodule
`default_nettype wire
